// ---- design/safe_torque_off_gate.sv ----
/*
  safe torque disable gate: blocks pwm gates on either request low,
  latches fault codes, releases through an auto-reset.
  assumes inputs synchronous to ref_clk_in, init_done_in from the cpu.
*/
module safe_torque_off_gate #(
  parameter int unsigned PWM_W = 6,
  parameter int unsigned BLOCK_CYC = torque_off_pkg::BLOCK_LIMIT_CYC,
  parameter int unsigned SKEW_CYCLES = torque_off_pkg::SKEW_CYC
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic torque_off_request_a_in,
  input wire logic torque_off_request_b_in,
  input wire logic [PWM_W-1:0] pwm_in,
  input wire logic init_done_in,
  input wire logic servo_on_in,
  input wire logic supply_fault_in,
  input wire logic input_ckt_fault_in,
  input wire logic buffer_ckt_fault_in,
  input wire logic [3:0] mode_in,
  output logic [PWM_W-1:0] pwm_out,
  output logic buffer_disable_out,
  output logic safe_torque_disable_out,
  output logic [3:0] display_mode_out,
  output logic [1:0] display_status_out,
  output logic [3:0] display_fault_out,
  output logic fault_active_out
);
  // ****************************************
  // state machine
  // ****************************************
  typedef enum logic [3:0] {
    ST_INIT = 4'b0001,
    ST_RUN = 4'b0010,
    ST_SAFE = 4'b0100,
    ST_RESET = 4'b1000
  } gate_state_e;

  gate_state_e state_r, state_nxt;
  logic [3:0] fault_r, fault_nxt;
  logic [torque_off_pkg::CNT_W-1:0] skew_r, skew_nxt;
  logic [PWM_W-1:0] pwm_r, pwm_nxt;
  logic block_r, block_nxt;
  logic [3:0] mode_r, mode_nxt;
  logic [1:0] status_r, status_nxt;
  logic [3:0] disp_fault_r, disp_fault_nxt;
  logic fault_act_r, fault_act_nxt;

  logic both_high, both_low, one_low, internal_fault;
  logic [3:0] int_code;

  // decode of requests and internal diagnosis
  always_comb begin
    both_high = torque_off_request_a_in & torque_off_request_b_in;
    both_low = ~torque_off_request_a_in & ~torque_off_request_b_in;
    one_low = torque_off_request_a_in ^ torque_off_request_b_in;
    internal_fault = supply_fault_in | input_ckt_fault_in | buffer_ckt_fault_in;
    // supply first: a bad rail makes the other diagnoses untrustworthy
    if (supply_fault_in) begin
      int_code = torque_off_pkg::FAULT_SUPPLY;
    end else if (input_ckt_fault_in) begin
      int_code = torque_off_pkg::FAULT_INPUT_CKT;
    end else if (buffer_ckt_fault_in) begin
      int_code = torque_off_pkg::FAULT_BUFFER_CKT;
    end else begin
      int_code = torque_off_pkg::FAULT_NONE;
    end
  end

  // next state and latched fault code
  always_comb begin
    state_nxt = state_r;
    fault_nxt = fault_r;
    skew_nxt = skew_r;
    // skew counter times one-channel-low; simultaneous drop is expected
    if (one_low) begin
      if (skew_r < torque_off_pkg::CNT_W'(SKEW_CYCLES)) begin
        skew_nxt = skew_r + 1'b1;
      end
    end else begin
      skew_nxt = '0;
    end
    case (state_r)
      ST_INIT: begin
        // hold until cpu init done, then enter safe state to qualify
        if (init_done_in) begin
          state_nxt = ST_SAFE;
        end
      end
      ST_RUN: begin
        if (internal_fault) begin
          state_nxt = ST_SAFE;
          fault_nxt = int_code;
        end else if (both_low) begin
          state_nxt = ST_SAFE;
          fault_nxt = torque_off_pkg::FAULT_EXT_REQ;
        end else if (one_low) begin
          state_nxt = ST_SAFE;
          fault_nxt = torque_off_pkg::FAULT_MISMATCH;
        end
      end
      ST_SAFE: begin
        // upgrade code while waiting; internal faults dominate
        if (internal_fault) begin
          fault_nxt = int_code;
        end else if (one_low && skew_r >= torque_off_pkg::CNT_W'(SKEW_CYCLES)
                     && (fault_r == torque_off_pkg::FAULT_EXT_REQ
                     || fault_r == torque_off_pkg::FAULT_NONE)) begin
          fault_nxt = torque_off_pkg::FAULT_MISMATCH;
        end else if (both_low && fault_r == torque_off_pkg::FAULT_NONE) begin
          // requests already low when the safe state began after init
          fault_nxt = torque_off_pkg::FAULT_EXT_REQ;
        end
        if (both_high && !servo_on_in && !internal_fault) begin
          state_nxt = ST_RESET;
        end
      end
      ST_RESET: begin
        // code clears only here, after release conditions held
        if (both_high && !servo_on_in && !internal_fault) begin
          state_nxt = ST_RUN;
          fault_nxt = torque_off_pkg::FAULT_NONE;
        end else begin
          // a fault arriving mid-release still gets its code shown
          state_nxt = ST_SAFE;
          if (internal_fault) begin
            fault_nxt = int_code;
          end
        end
      end
      default: begin
        state_nxt = ST_SAFE;
      end
    endcase
  end

  // gate path: blocked one cycle after a request drops, far inside limit
  always_comb begin
    block_nxt = 1'b1;
    if (state_nxt == ST_RUN && both_high && !internal_fault) begin
      block_nxt = 1'b0;
    end
    // all gates off, never a braking pattern, so the motor coasts
    pwm_nxt = block_nxt ? '0 : pwm_in;
  end

  // display contents
  always_comb begin
    mode_nxt = mode_in;
    disp_fault_nxt = fault_nxt;
    fault_act_nxt = (fault_nxt != torque_off_pkg::FAULT_NONE);
    case (state_nxt)
      ST_INIT: status_nxt = torque_off_pkg::STAT_INIT;
      ST_RUN: status_nxt = torque_off_pkg::STAT_RUN;
      ST_SAFE: status_nxt = torque_off_pkg::STAT_SAFE;
      ST_RESET: status_nxt = torque_off_pkg::STAT_RESET;
      default: status_nxt = torque_off_pkg::STAT_SAFE;
    endcase
  end

  // registers; reset leaves the buffer disabled like the pull-up
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_r <= ST_INIT;
      fault_r <= torque_off_pkg::FAULT_NONE;
      skew_r <= '0;
      pwm_r <= '0;
      block_r <= 1'b1;
      mode_r <= 4'h0;
      status_r <= torque_off_pkg::STAT_INIT;
      disp_fault_r <= torque_off_pkg::FAULT_NONE;
      fault_act_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      fault_r <= fault_nxt;
      skew_r <= skew_nxt;
      pwm_r <= pwm_nxt;
      block_r <= block_nxt;
      mode_r <= mode_nxt;
      status_r <= status_nxt;
      disp_fault_r <= disp_fault_nxt;
      fault_act_r <= fault_act_nxt;
    end
  end

  assign pwm_out = pwm_r;
  assign buffer_disable_out = block_r;
  assign safe_torque_disable_out = block_r;
  assign display_mode_out = mode_r;
  assign display_status_out = status_r;
  assign display_fault_out = disp_fault_r;
  assign fault_active_out = fault_act_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence req_drop_s;
    !(torque_off_request_a_in && torque_off_request_b_in);
  endsequence

  sequence gates_dead_s;
    buffer_disable_out && pwm_out == '0;
  endsequence

  // release conditions as the auto-reset sees them
  sequence release_hold_s;
    both_high && !servo_on_in && !internal_fault;
  endsequence

  // first step of the auto-reset: safe state with every condition met
  sequence safe_ready_s;
    state_r == ST_SAFE && both_high && !servo_on_in && !internal_fault;
  endsequence

  // ****************************************
  // assertion helper
  // ****************************************
  // cycles a request has been low with the gates still live; one is the
  // most the gate path allows, the 30 ms limit is only a backstop
  logic [torque_off_pkg::CNT_W-1:0] live_cnt_r, live_cnt_nxt;

  always_comb begin
    live_cnt_nxt = '0;
    if (!both_high && !block_r) begin
      live_cnt_nxt = live_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      live_cnt_r <= '0;
    end else begin
      live_cnt_r <= live_cnt_nxt;
    end
  end

  // gate path
  pwm_needs_both_a: assert property (!buffer_disable_out |->
    $past(torque_off_request_a_in) && $past(torque_off_request_b_in))
    else $error("pwm enabled with a request low");
  block_timely_a: assert property (req_drop_s |=> gates_dead_s)
    else $error("gates not blocked after request drop");
  block_limit_a: assert property (live_cnt_r < torque_off_pkg::CNT_W'(BLOCK_CYC))
    else $error("gates live too long after request drop");
  coast_zero_a: assert property (buffer_disable_out |-> pwm_out == '0)
    else $error("gate drive present while blocked");
  // fault codes
  ext_code_a: assert property (state_r == ST_RUN && both_low && !internal_fault
    |=> display_fault_out == torque_off_pkg::FAULT_EXT_REQ)
    else $error("external request code missing");
  idle_code_a: assert property (state_r == ST_SAFE && both_low && !internal_fault
    && fault_r == torque_off_pkg::FAULT_NONE
    |=> display_fault_out == torque_off_pkg::FAULT_EXT_REQ)
    else $error("external request code missing in safe state");
  mismatch_code_a: assert property (state_r == ST_RUN && one_low && !internal_fault
    |=> display_fault_out == torque_off_pkg::FAULT_MISMATCH && buffer_disable_out)
    else $error("inconsistency code missing");
  supply_code_a: assert property (supply_fault_in && state_r != ST_INIT
    |=> display_fault_out == torque_off_pkg::FAULT_SUPPLY)
    else $error("supply fault code missing");
  input_ckt_a: assert property (input_ckt_fault_in && !supply_fault_in
    && state_r != ST_INIT |=> buffer_disable_out
    && display_fault_out == torque_off_pkg::FAULT_INPUT_CKT)
    else $error("input circuit fault not handled");
  buffer_ckt_a: assert property (buffer_ckt_fault_in |=> buffer_disable_out)
    else $error("buffer circuit fault not handled");
  buffer_code_a: assert property (buffer_ckt_fault_in && !supply_fault_in
    && !input_ckt_fault_in && state_r != ST_INIT
    |=> display_fault_out == torque_off_pkg::FAULT_BUFFER_CKT)
    else $error("buffer circuit fault code missing");
  // start-up, release and display
  init_hold_a: assert property (state_r == ST_INIT |-> buffer_disable_out)
    else $error("buffer enabled during initialization");
  release_cond_a: assert property ($fell(buffer_disable_out) |->
    $past(state_r) == ST_RESET && $past(servo_on_in) == 1'b0)
    else $error("release without auto-reset");
  release_path_a: assert property (safe_ready_s ##1 release_hold_s
    |=> !buffer_disable_out)
    else $error("release conditions held but gates stay blocked");
  run_cmd_hold_a: assert property (state_r == ST_SAFE && servo_on_in
    |=> buffer_disable_out && state_r == ST_SAFE)
    else $error("left safe state with run command active");
  code_latched_a: assert property (state_r == ST_SAFE && state_nxt == ST_SAFE
    && fault_r != torque_off_pkg::FAULT_NONE |=> fault_r != torque_off_pkg::FAULT_NONE)
    else $error("fault code cleared early");
  mode_show_a: assert property (!$past(reset_in)
    |-> display_mode_out == $past(mode_in))
    else $error("display mode does not follow selection");
  run_status_a: assert property ((display_status_out == torque_off_pkg::STAT_RUN)
    == !buffer_disable_out)
    else $error("run status disagrees with gate state");
  active_flag_a: assert property (fault_active_out
    == (display_fault_out != torque_off_pkg::FAULT_NONE))
    else $error("fault flag disagrees with fault code");
endmodule : safe_torque_off_gate

// ---- inc/torque_off_pkg.sv ----
/*
  constants for the safe torque disable gate: fault codes, display
  states, timing counts.
  assumes a single 25 MHz clock and synchronous active-high reset.
*/
package torque_off_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned BLOCK_LIMIT_MS = 30;
  // longest time rounds down
  localparam int unsigned BLOCK_LIMIT_CYC = (CLK_HZ / 1000) * BLOCK_LIMIT_MS;
  // mismatch between channels tolerated in the safe state before an external request code upgrades to inconsistency
  localparam int unsigned SKEW_MS = 10;
  localparam int unsigned SKEW_CYC = (CLK_HZ / 1000) * SKEW_MS;
  localparam int unsigned CNT_W = 24;

  // ****************************************
  // fault codes shown on the display, suffix of the 150 group
  // ****************************************
  localparam logic [3:0] FAULT_NONE = 4'hf;
  localparam logic [3:0] FAULT_EXT_REQ = 4'h0;
  localparam logic [3:0] FAULT_MISMATCH = 4'h1;
  localparam logic [3:0] FAULT_SUPPLY = 4'h2;
  localparam logic [3:0] FAULT_INPUT_CKT = 4'h3;
  localparam logic [3:0] FAULT_BUFFER_CKT = 4'h4;

  // ****************************************
  // drive status shown on the display
  // ****************************************
  localparam logic [1:0] STAT_INIT = 2'h0;
  localparam logic [1:0] STAT_RUN = 2'h1;
  localparam logic [1:0] STAT_SAFE = 2'h2;
  localparam logic [1:0] STAT_RESET = 2'h3;
endpackage : torque_off_pkg

// ---- tb/safety_relay_model.sv ----
/*
  safety relay model that drives the two torque-off request channels.
  assumes its commands come from the bench, changed just after a clock edge.
*/
module safety_relay_model (
  input wire logic open_both_in,
  input wire logic open_a_in,
  output logic request_a_out,
  output logic request_b_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // open_both_in opens both contacts together; open_a_in opens channel a alone, so the channels can skew
  assign request_a_out = !(open_both_in || open_a_in);
  assign request_b_out = !open_both_in;
endmodule : safety_relay_model

// ---- tb/tb_safe_torque_off_gate.sv ----
/*
  directed bench for the safe torque disable gate.
  assumes the relay model in its own file and the design's package.
*/
module tb_safe_torque_off_gate;
  timeunit 1ns;
  timeprecision 1ps;
  // short skew window keeps the mismatch case quick
  localparam int unsigned SKEW = 8;
  logic ref_clk_in, reset_in, open_both, open_a, req_a, req_b;
  logic init_done_in, servo_on_in, supply_f, input_f, buffer_f;
  logic buffer_disable, std_out, fault_active;
  logic [5:0] pwm_in, pwm_out;
  logic [3:0] mode_in, disp_mode, disp_fault;
  logic [1:0] disp_status;
  logic [3:0] codes [3];
  int err_total, cmp_count;

  // ****************************************
  // clock, watchdog, instances
  // ****************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = !ref_clk_in;
  end
  // the run needs about a hundred cycles, so 100 us means a hang
  initial begin
    #100us;
    err_total++;
    complete_run();
  end
  safety_relay_model u_safety_relay_model (.open_both_in(open_both), .open_a_in(open_a),
    .request_a_out(req_a), .request_b_out(req_b));
  safe_torque_off_gate #(.SKEW_CYCLES(SKEW)) u_safe_torque_off_gate (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .torque_off_request_a_in(req_a),
    .torque_off_request_b_in(req_b), .pwm_in(pwm_in), .init_done_in(init_done_in),
    .servo_on_in(servo_on_in), .supply_fault_in(supply_f), .input_ckt_fault_in(input_f),
    .buffer_ckt_fault_in(buffer_f), .mode_in(mode_in), .pwm_out(pwm_out),
    .buffer_disable_out(buffer_disable), .safe_torque_disable_out(std_out),
    .display_mode_out(disp_mode), .display_status_out(disp_status),
    .display_fault_out(disp_fault), .fault_active_out(fault_active));

  // ****************************************
  // tasks
  // ****************************************
  // inputs always move 1 ns after the edge, outputs are settled then
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask : tick
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // release goes through the reset state, bounded at 20 cycles
  task automatic wait_run();
    for (int i = 0; i < 20 && disp_status !== torque_off_pkg::STAT_RUN; i++) tick(1);
    check("status", torque_off_pkg::STAT_RUN, disp_status);
  endtask : wait_run
  task automatic complete_run();
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run

  // ****************************************
  // tests
  // ****************************************
  initial begin
    {reset_in, open_both, open_a, init_done_in, servo_on_in} = 5'h10;
    {supply_f, input_f, buffer_f} = 3'h0;
    pwm_in = 6'h2d;
    mode_in = 4'h5;
    codes = '{torque_off_pkg::FAULT_SUPPLY, torque_off_pkg::FAULT_INPUT_CKT,
      torque_off_pkg::FAULT_BUFFER_CKT};
    err_total = 0;
    cmp_count = 0;
    tick(8);
    reset_in = 1'b0;
    check("disable", 8'h01, buffer_disable);
    check("fault", 8'h0f, disp_fault);
    tick(4);
    check("pwm", 8'h00, pwm_out);
    check("status", torque_off_pkg::STAT_INIT, disp_status);
    init_done_in = 1'b1;
    wait_run();
    tick(2);
    check("pwm", 8'h2d, pwm_out);
    check("mode", 8'h05, disp_mode);
    open_both = 1'b1;
    tick(2);
    check("pwm", 8'h00, pwm_out);
    check("std", 8'h01, std_out);
    check("fault", torque_off_pkg::FAULT_EXT_REQ, disp_fault);
    // run command still on, so release must wait
    servo_on_in = 1'b1;
    open_both = 1'b0;
    tick(6);
    check("status", torque_off_pkg::STAT_SAFE, disp_status);
    check("fault", torque_off_pkg::FAULT_EXT_REQ, disp_fault);
    servo_on_in = 1'b0;
    wait_run();
    check("fault", torque_off_pkg::FAULT_NONE, disp_fault);
    open_a = 1'b1;
    tick(SKEW + 4);
    check("pwm", 8'h00, pwm_out);
    check("fault", torque_off_pkg::FAULT_MISMATCH, disp_fault);
    open_a = 1'b0;
    wait_run();
    // both drop, then one returns early: past the window the code upgrades
    open_both = 1'b1;
    tick(2);
    check("fault", torque_off_pkg::FAULT_EXT_REQ, disp_fault);
    {open_both, open_a} = 2'h1;
    tick(4);
    check("fault", torque_off_pkg::FAULT_EXT_REQ, disp_fault);
    tick(SKEW);
    check("fault", torque_off_pkg::FAULT_MISMATCH, disp_fault);
    open_a = 1'b0;
    wait_run();
    // each internal fault alone, then recovery
    for (int k = 0; k < 3; k++) begin
      {supply_f, input_f, buffer_f} = 3'h4 >> k;
      tick(3);
      check("disable", 8'h01, buffer_disable);
      check("fault", codes[k], disp_fault);
      check("active", 8'h01, fault_active);
      {supply_f, input_f, buffer_f} = 3'h0;
      wait_run();
      check("active", 8'h00, fault_active);
    end
    // reset in mid-run with both requests dropped: init, then safe with code
    reset_in = 1'b1;
    open_both = 1'b1;
    tick(2);
    check("disable", 8'h01, buffer_disable);
    check("status", torque_off_pkg::STAT_INIT, disp_status);
    reset_in = 1'b0;
    tick(3);
    check("status", torque_off_pkg::STAT_SAFE, disp_status);
    check("fault", torque_off_pkg::FAULT_EXT_REQ, disp_fault);
    open_both = 1'b0;
    wait_run();
    check("pwm", 8'h2d, pwm_out);
    complete_run();
  end
endmodule : tb_safe_torque_off_gate
